//--- inc/flash_sec_defs.svh
// register offsets, field positions and reset values of the flash security block
`ifndef FLASH_SEC_DEFS_SVH
`define FLASH_SEC_DEFS_SVH
`define ADDR_OPTION      16'h1800
`define ADDR_CONFIG      16'h1801
`define ADDR_PROTECT     16'h1802
`define ADDR_STATUS      16'h1803
`define KEY_BASE         16'hffb0
`define KEY_LAST         16'hffb7
`define OPT_BACKDOOR_ENABLE_BIT    7
`define OPT_NORED_BIT    6
`define OPT_USED_MASK    8'hc3
`define CFG_RW_MASK      8'he0
`define CFG_KEY_ACCESS_BIT_BIT   5
`define PROT_DIS_BIT     0
`define SEC_UNSECURED    2'h2
`define CONFIG_RESET     8'h00
`define KEY_COUNT        4'h8
`endif

//--- inc/flash_sec_pkg.sv
// types of the flash security block
package flash_sec_pkg;
  typedef enum logic [1:0] {LOAD, RUN} phase_t;
  typedef struct packed {
    phase_t     phase;
    logic [7:0] option;
    logic [7:0] config_r;
    logic [7:0] protect;
    logic       unsecured;
    logic [3:0] key_count;
    logic       key_ok;
    logic [7:0] rdata;
  } state_t;
endpackage

//--- core/flash_security_option_protect.sv
// flash option, security, configuration and block protection control
// Notes on behaviour
// - option shadow reloads from stored byte each reset
// - option bits five to two read zero
// - option shadow readable, writes ignored
// - backdoor refused while backdoor enable clear
// - matching eight-byte key unsecures until reset
// - key bytes accepted from firmware only
// - redirect disable bit turns off redirection
// - only code one-zero is unsecured
// - successful blank check unsecures device
// - config bits seven to five writable, rest zero
// - key-access clear sends key writes to commands
// - key-access set routes writes to comparator
// - clearing key-access compares the eight bytes
// - protection shadow reloads from stored byte each reset
// - protection writable only by background debug
// - protect-select sets unprotected high boundary
// - block erase or program inside protected region
// - protection disable bit protects nothing
`timescale 1ns/1ps
`include "flash_sec_defs.svh"
module flash_security_option_protect
  import flash_sec_pkg::*;
#(
  parameter int ADDR_W = 16
)
(
  input  wire logic              SYS_CLK_I,
  input  wire logic              RESET_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [7:0]        WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  input  wire logic              DEBUG_ACCESS_I,
  input  wire logic [7:0]        STORED_OPTION_BYTE_I,
  input  wire logic [7:0]        STORED_PROTECTION_BYTE_I,
  input  wire logic [63:0]       STORED_BACKDOOR_KEY_I,
  input  wire logic              BLANK_CHECK_PASS_I,
  input  wire logic [ADDR_W-1:0] FLASH_TARGET_I,
  output logic      [7:0]        RDATA_O,
  output logic                   COMMAND_WRITE_O,
  output logic                   SECURE_O,
  output logic                   REDIRECT_ENABLE_O,
  output logic                   TARGET_PROTECTED_O
);

  initial
  begin
    if (ADDR_W < 16)
      $error("address width below 16 cannot reach key window");
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic logic in_key_window(input logic [ADDR_W-1:0] a);
    in_key_window = (a >= ADDR_W'(`KEY_BASE)) && (a <= ADDR_W'(`KEY_LAST));
  endfunction

  function automatic logic [7:0] key_byte(input logic [63:0] k, input logic [3:0] i);
    key_byte = k[63 - 8*i -: 8];
  endfunction

  state_t r;
  state_t next_r;
  logic   key_write;
  logic   key_access_bit_fall;

  ////////////////////////////////////////////////////////////////////////
  // key window writes go to comparator only with key access set
  always_comb
  begin
    key_write = WR_I && in_key_window(ADDR_I) && r.config_r[`CFG_KEY_ACCESS_BIT_BIT];
    // debug traffic never feeds the comparator
    key_write = key_write && !DEBUG_ACCESS_I;
  end
  assign COMMAND_WRITE_O = WR_I && in_key_window(ADDR_I)
                           && !r.config_r[`CFG_KEY_ACCESS_BIT_BIT];
  // any clear restarts the counter, so a debug clear leaves no stale bytes behind
  assign key_access_bit_fall = WR_I && (ADDR_I == ADDR_W'(`ADDR_CONFIG))
                       && r.config_r[`CFG_KEY_ACCESS_BIT_BIT] && !WDATA_I[`CFG_KEY_ACCESS_BIT_BIT];

  always_comb
  begin
    next_r = r;
    if (r.phase == LOAD)
    begin
      // shadows taken one edge after reset release, never in reset itself
      next_r.option  = STORED_OPTION_BYTE_I & `OPT_USED_MASK;
      next_r.protect = STORED_PROTECTION_BYTE_I;
      next_r.phase   = RUN;
    end
    else
    begin
      // option shadow has no bus write path; only unsecuring rewrites its low two bits
      if (WR_I && ADDR_I == ADDR_W'(`ADDR_CONFIG))
        next_r.config_r = WDATA_I & `CFG_RW_MASK;
      if (WR_I && DEBUG_ACCESS_I && ADDR_I == ADDR_W'(`ADDR_PROTECT))
        next_r.protect = WDATA_I;
      if (key_write)
      begin
        // bytes must arrive in ascending address order
        if (r.key_count < `KEY_COUNT)
        begin
          if (ADDR_I != ADDR_W'(`KEY_BASE) + ADDR_W'(r.key_count)
              || WDATA_I != key_byte(STORED_BACKDOOR_KEY_I, r.key_count))
            next_r.key_ok = 1'b0;
          next_r.key_count = r.key_count + 4'h1;
        end
      end
      if (key_access_bit_fall)
      begin
        if (r.key_ok && r.key_count == `KEY_COUNT && !DEBUG_ACCESS_I
            && r.option[`OPT_BACKDOOR_ENABLE_BIT])
          next_r.unsecured = 1'b1;
        next_r.key_count = 4'h0;
        next_r.key_ok    = 1'b1;
      end
      if (BLANK_CHECK_PASS_I)
        next_r.unsecured = 1'b1;
      if (next_r.unsecured)
        next_r.option[1:0] = `SEC_UNSECURED;
    end
    next_r.rdata = 8'h00;
    if (RD_I)
    begin
      unique case (ADDR_I)
        ADDR_W'(`ADDR_OPTION):  next_r.rdata = r.option & `OPT_USED_MASK;
        ADDR_W'(`ADDR_CONFIG):  next_r.rdata = r.config_r & `CFG_RW_MASK;
        ADDR_W'(`ADDR_PROTECT): next_r.rdata = r.protect;
        ADDR_W'(`ADDR_STATUS):  next_r.rdata = {7'h00, SECURE_O};
        default:                next_r.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RESET_I)
  begin
    if (RESET_I)
    begin
      r           <= '0;
      r.phase     <= LOAD;
      r.config_r  <= `CONFIG_RESET;
      r.key_ok    <= 1'b1;
    end
    else
      r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////
  assign RDATA_O           = r.rdata;
  assign SECURE_O          = (r.option[1:0] != `SEC_UNSECURED);
  assign REDIRECT_ENABLE_O = !r.option[`OPT_NORED_BIT];
  // protected region lies above the boundary built from the select field
  assign TARGET_PROTECTED_O = !r.protect[`PROT_DIS_BIT]
    && (FLASH_TARGET_I[15:9] > r.protect[7:1]);

endmodule

//--- testbench/flash_sec_asserts.sv
// port checker of the flash security block
`timescale 1ns/1ps
`include "flash_sec_defs.svh"
module flash_sec_asserts #(parameter int ADDR_W = 16)
(
  input wire logic              SYS_CLK_I,
  input wire logic              RESET_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic              WR_I,
  input wire logic              RD_I,
  input wire logic              DEBUG_ACCESS_I,
  input wire logic              BLANK_CHECK_PASS_I,
  input wire logic [ADDR_W-1:0] FLASH_TARGET_I,
  input wire logic [7:0]        RDATA_O,
  input wire logic              COMMAND_WRITE_O,
  input wire logic              SECURE_O,
  input wire logic              REDIRECT_ENABLE_O,
  input wire logic              TARGET_PROTECTED_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RESET_I);
  chk_cmd_window: assert property (COMMAND_WRITE_O |-> WR_I
    && ADDR_I >= `KEY_BASE && ADDR_I <= `KEY_LAST) else $error("command outside key window");
  chk_opt_zero: assert property (RD_I && ADDR_I == `ADDR_OPTION |=> RDATA_O[5:2] == 4'h0)
    else $error("option unused bits set");
  chk_cfg_zero: assert property (RD_I && ADDR_I == `ADDR_CONFIG |=> RDATA_O[4:0] == 5'h00)
    else $error("config low bits set");
  chk_redir_bit: assert property (RD_I && ADDR_I == `ADDR_OPTION |=>
    RDATA_O[6] != REDIRECT_ENABLE_O) else $error("redirect differs from option");
  chk_prot_region: assert property (RD_I && ADDR_I == `ADDR_PROTECT |=> TARGET_PROTECTED_O ==
    (!RDATA_O[0] && FLASH_TARGET_I[15:9] > RDATA_O[7:1])) else $error("protect region wrong");
  chk_unsec_held: assert property (!SECURE_O |=> !SECURE_O) else $error("security returned");
  // first load after reset may move both levels, so skip two edges
  chk_redir_stable: assert property (!$past(RESET_I) && !$past(RESET_I, 2)
    |-> $stable(REDIRECT_ENABLE_O)) else $error("redirect moved without reset");
  chk_unsec_cause: assert property ($fell(SECURE_O) && !$past(RESET_I, 2) |->
    $past(BLANK_CHECK_PASS_I) || ($past(WR_I) && $past(ADDR_I) == `ADDR_CONFIG
    && !$past(DEBUG_ACCESS_I))) else $error("unsecured without cause");
endmodule
bind flash_security_option_protect flash_sec_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

//--- testbench/tb_flash_security_option_protect.sv
// self-checking bench of the flash security block
`timescale 1ns/1ps
module tb_flash_security_option_protect;
  logic SYS_CLK_I = 0, RESET_I = 1, WR_I = 0, RD_I = 0, DEBUG_ACCESS_I = 0, BLANK_CHECK_PASS_I = 0;
  logic [15:0] ADDR_I = 0, FLASH_TARGET_I = 16'hffb0;
  logic [7:0] WDATA_I = 0, RDATA_O, sopt = 8'hbf, sprot = 8'h40, v;
  logic [63:0] key = 64'h0123456789abcdef;
  logic COMMAND_WRITE_O, SECURE_O, REDIRECT_ENABLE_O, TARGET_PROTECTED_O, cw;
  int n_fail = 0, checks = 0;
  always #50 SYS_CLK_I = ~SYS_CLK_I;
  flash_security_option_protect u_dut (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
    .DEBUG_ACCESS_I(DEBUG_ACCESS_I), .STORED_OPTION_BYTE_I(sopt),
    .STORED_PROTECTION_BYTE_I(sprot), .STORED_BACKDOOR_KEY_I(key),
    .BLANK_CHECK_PASS_I(BLANK_CHECK_PASS_I), .FLASH_TARGET_I(FLASH_TARGET_I),
    .RDATA_O(RDATA_O), .COMMAND_WRITE_O(COMMAND_WRITE_O), .SECURE_O(SECURE_O),
    .REDIRECT_ENABLE_O(REDIRECT_ENABLE_O), .TARGET_PROTECTED_O(TARGET_PROTECTED_O));
  task automatic chk(string n, logic [7:0] s, logic [7:0] e);
    checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    if (n_fail == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // bus cycles; strobes stay up between back-to-back writes
  task automatic rst(logic [7:0] o);
    sopt <= o; RESET_I <= 1; WR_I <= 0; RD_I <= 0;
    repeat (4) @(posedge SYS_CLK_I);
    RESET_I <= 0;
    repeat (2) @(posedge SYS_CLK_I);
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    ADDR_I <= a; WDATA_I <= d; WR_I <= 1; RD_I <= 0;
    #1 cw = COMMAND_WRITE_O;
    @(posedge SYS_CLK_I);
  endtask
  task automatic rd(logic [15:0] a);
    ADDR_I <= a; RD_I <= 1; WR_I <= 0;
    @(posedge SYS_CLK_I);
    RD_I <= 0;
    #1 v = RDATA_O;
    @(posedge SYS_CLK_I);
  endtask
  task automatic key_seq(logic [63:0] k);
    wr(16'h1801, 8'h20);
    for (int i = 0; i < 8; i++) wr(16'hffb0 + i[15:0], k[63-8*i -: 8]);
    wr(16'h1801, 8'h00);
    rd(16'h1803);
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst(8'hbf);
    rd(16'h1800); chk("option", v, 8'h83);
    chk("secure", SECURE_O, 1); chk("redirect", REDIRECT_ENABLE_O, 1);
    wr(16'h1800, 8'hff); rd(16'h1800); chk("option ro", v, 8'h83);
    rd(16'h1802); chk("protect", v, 8'h40); chk("prot hit", TARGET_PROTECTED_O, 1);
    FLASH_TARGET_I <= 16'h3000; rd(16'h1802); chk("prot miss", TARGET_PROTECTED_O, 0);
    wr(16'h1802, 8'h01); rd(16'h1802); chk("protect user", v, 8'h40);
    DEBUG_ACCESS_I <= 1; wr(16'h1802, 8'h01); DEBUG_ACCESS_I <= 0; rd(16'h1802);
    FLASH_TARGET_I <= 16'hffb0; rd(16'h1802); chk("prot off", TARGET_PROTECTED_O, 0);
    wr(16'hffb0, 8'h00); chk("cmd", cw, 1);
    wr(16'h1801, 8'hff); rd(16'h1801); chk("config", v, 8'he0);
    wr(16'hffb1, 8'h00); chk("no cmd", cw, 0);
    DEBUG_ACCESS_I <= 1; key_seq(key); DEBUG_ACCESS_I <= 0; chk("dbg key", SECURE_O, 1);
    key_seq(key ^ 64'h1); chk("bad key", SECURE_O, 1);
    key_seq(key); chk("key ok", SECURE_O, 0); chk("stat", v, 8'h00);
    rst(8'h43); chk("no redir", REDIRECT_ENABLE_O, 0);
    key_seq(key); chk("key off", SECURE_O, 1);
    BLANK_CHECK_PASS_I <= 1; @(posedge SYS_CLK_I); BLANK_CHECK_PASS_I <= 0;
    @(posedge SYS_CLK_I); chk("blank", SECURE_O, 0);
    rst(8'h02); chk("code 10", SECURE_O, 0);
    finish_test;
  end
  initial
  begin
    #50000 n_fail++;
    finish_test;
  end
endmodule
